/* File: hw/tsc_map.vh */
// constants for the test sequence controller
`ifndef TSC_MAP_VH
`define TSC_MAP_VH
// register offsets
`define TSC_A_CTRL 8'h00
`define TSC_A_VOLT 8'h04
`define TSC_A_TIMER 8'h08
`define TSC_A_BUZZ 8'h0c
`define TSC_A_RSEL 8'h10
`define TSC_A_SLOT 8'h14
`define TSC_A_CMD 8'h18
`define TSC_A_STATUS 8'h1c
`define TSC_A_HELD 8'h20
// control bits
`define TSC_C_INS 0
`define TSC_C_CHK_END 1
`define TSC_C_PASS_HOLD 2
`define TSC_C_FAIL_HOLD 3
`define TSC_C_MOMENT 4
`define TSC_C_DOUBLE 5
`define TSC_C_RESTRICT 6
`define TSC_C_PC_START 7
`define TSC_C_END_JUDGE 8
`define TSC_C_AUTO_RANGE 9
`define TSC_C_RANGE_LO 12
`define TSC_C_RANGE_HI 15
// slot and command bits
`define TSC_S_STORE 8
`define TSC_S_LOAD 9
`define TSC_K_START 0
`define TSC_K_STOP 1
// reset values
`define TSC_CTRL_RST 16'h0000
`define TSC_VOLT_RST 16'h0000
`define TSC_TIMER_RST 16'h0000
`define TSC_BUZZ_RST 16'h0000
`define TSC_RSEL_RST 16'h0000
// slot count and voltage window
`define TSC_SLOTS 10
`define TSC_LOW_KV_V 16'h03e8
`define TSC_FIX_TOL_V 16'h0032
`define TSC_PCT_DIV 16'h0014
// timing
`define TSC_CLK_HZ 40000000
`define TSC_DA_MS 500
`define TSC_MS_CYC (`TSC_CLK_HZ / 1000)
`define TSC_DA_CYC (`TSC_MS_CYC * `TSC_DA_MS)
`define TSC_RAMP_MS 100
`define TSC_BUZZ_CYC 4000
`endif

/* File: hw/tsc_slots.v */
// stored test-condition slots, one bank per test mode
`timescale 1ns/100ps
`default_nettype none
`include "tsc_map.vh"
module tsc_slots
#(
    parameter N = `TSC_SLOTS,
    parameter W = 16
)
(
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // access
    input wire mode,
    input wire [3:0] idx,
    input wire store,
    input wire [W-1:0] cur_volt,
    input wire [W-1:0] cur_timer,
    output wire [W-1:0] slot_volt,
    output wire [W-1:0] slot_timer,
    output wire idx_ok
);
    reg [W-1:0] volt_m [0:2*N-1];
    reg [W-1:0] timer_m [0:2*N-1];
    wire [4:0] base = mode ? N[4:0] : 5'h00;
    wire [4:0] sel = base + {1'b0, idx};
    integer i;

    assign idx_ok = ({1'b0, idx} < N[4:0]);
    assign slot_volt = idx_ok ? volt_m[sel] : {W{1'b0}};
    assign slot_timer = idx_ok ? timer_m[sel] : {W{1'b0}};

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (i = 0; i < 2 * N; i = i + 1)
            begin
                volt_m[i] <= {W{1'b0}};
                timer_m[i] <= {W{1'b0}};
            end
        end
        else if (store && idx_ok)
        begin
            volt_m[sel] <= cur_volt;
            timer_m[sel] <= cur_timer;
        end
    end
endmodule
`default_nettype wire

/* File: hw/tsc_vcomp.v */
// output voltage window check against the programmed voltage
`timescale 1ns/100ps
`default_nettype none
`include "tsc_map.vh"
module tsc_vcomp
(
    // voltages in volts
    input wire [15:0] vset,
    input wire [15:0] vmeas,
    output wire in_tol
);
    wire [15:0] tol;
    wire [15:0] diff;

    // at or under one kilovolt the fixed window applies
    assign tol = (vset <= `TSC_LOW_KV_V) ? `TSC_FIX_TOL_V
                                         : vset / `TSC_PCT_DIV;
    assign diff = (vmeas > vset) ? vmeas - vset : vset - vmeas;
    assign in_tol = (diff <= tol);
endmodule
`default_nettype wire

/* File: hw/tsc_seq_ctrl.v */
// test sequence controller top
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "tsc_map.vh"
// How it works
// - ten condition slots per test mode, stored from or loaded to settings.
// - withstand test starts only with output within five percent of set.
// - at or under one kilovolt the start window is fifty volts.
// - optional: voltage window checked just before test end instead.
// - a forced stop freezes the last measured value on display.
// - pass hold option keeps pass shown until a release.
// - fail hold option keeps fail shown until a release.
// - separate buzzer volumes for pass and fail, applied per result.
// - momentary mode outputs only while start is held.
// - remote and external held start act like the panel key.
// - double action accepts start only within half a second of stop.
// - restricted release clears held results only by panel stop.
// - setting accepts or rejects start commands from the pc link.
// - insulation test ends at timer expiry, or optionally at first judgement while a timer is set.
// - insulation range fixed or automatic by setting.
// - status relay closes when any selected condition holds.
// - start priority: pc link, remote box, external, panel.
module tsc_seq_ctrl
#(
    parameter DA_CYC = `TSC_DA_CYC,
    parameter MS_CYC = `TSC_MS_CYC,
    parameter RAMP_MS = `TSC_RAMP_MS,
    parameter BUZZ_CYC = `TSC_BUZZ_CYC
)
(
    // clock and reset
    input wire mclk,
    input wire rst_b,
    // register port
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata_q,
    // start and stop sources
    input wire panel_start,
    input wire panel_stop,
    input wire remote_start,
    input wire remote_stop,
    input wire ext_start_n,
    input wire ext_stop_n,
    input wire ext_enable_n,
    input wire interlock_n,
    // measurement path
    input wire [15:0] vout_meas,
    input wire [15:0] meas_value,
    input wire judge_pass,
    input wire judge_fail,
    input wire power_ok,
    // source and results
    output reg [15:0] vset_q,
    output reg hv_on_q,
    output reg test_q,
    output reg pass_q,
    output reg fail_q,
    output reg ready_q,
    output reg [15:0] held_value_q,
    output reg buzz_on_q,
    output reg [3:0] buzz_vol_q,
    output reg range_auto_q,
    output reg [3:0] range_sel_q,
    output reg external_control_selected_q,
    output reg relay_q
);
    localparam S_IDLE = 2'd0;
    localparam S_RAMP = 2'd1;
    localparam S_TEST = 2'd2;
    localparam S_DONE = 2'd3;

    reg [15:0] ctrl_q;
    reg [15:0] timer_q;
    reg [15:0] buzz_q;
    reg [15:0] rsel_q;
    reg [3:0] slot_idx_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [1:0] src_q;
    reg held_prev_q;
    reg [2:0] stop_prev_q;
    reg [24:0] da_cnt_q;
    reg [15:0] ms_cnt_q;
    reg [15:0] ramp_q;
    reg [15:0] time_q;
    reg [12:0] buzz_cnt_q;
    reg refused_q;
    reg end_pass;
    reg end_fail;
    reg abort;
    reg to_test;
    reg refuse;

    function wr_hit;
        input [7:0] a;
        begin
            wr_hit = reg_wr && (reg_addr == a);
        end
    endfunction

    wire ins = ctrl_q[`TSC_C_INS];
    wire ext_en = ~ext_enable_n;
    wire lock = ~interlock_n;
    wire ext_start = ext_en & ~ext_start_n;
    wire ext_stop = ext_en & ~ext_stop_n;
    wire pc_start = wr_hit(`TSC_A_CMD) & reg_wdata[`TSC_K_START]
                    & ctrl_q[`TSC_C_PC_START];
    wire pc_stop = wr_hit(`TSC_A_CMD) & reg_wdata[`TSC_K_STOP];
    // any held source keeps a momentary test alive
    wire held_now = remote_start | ext_start | panel_start;
    wire start_rise = pc_start | (held_now & ~held_prev_q);
    wire [2:0] stop_now = {ext_stop, remote_stop, panel_stop};
    wire [2:0] stop_rise = stop_now & ~stop_prev_q;
    wire stop_ev = pc_stop | (|stop_rise);
    wire da_open = (da_cnt_q != 25'h0000000);
    wire da_ok = ~ctrl_q[`TSC_C_DOUBLE] | da_open;
    wire start_ok = start_rise & (state_q == S_IDLE) & ~lock & da_ok;
    // with restricted release, remote and external stops cannot clear a held result
    wire release_ev = ctrl_q[`TSC_C_RESTRICT] ? stop_rise[0]
                                              : stop_ev;
    wire kill = stop_ev | lock
                | (ctrl_q[`TSC_C_MOMENT] & ~held_now & ~pc_start);
    wire active = (state_q == S_RAMP) | (state_q == S_TEST);
    wire tick = active & (ms_cnt_q == MS_CYC[15:0] - 16'h0001);
    wire timer_set = (timer_q != 16'h0000);
    wire judge_ends = ~ins | (ctrl_q[`TSC_C_END_JUDGE] & timer_set);
    wire [15:0] slot_volt;
    wire [15:0] slot_timer;
    wire slot_ok;
    wire in_tol;
    wire [7:0] cond;

    tsc_slots u_slots
    (
        .mclk(mclk),
        .rst_b(rst_b),
        .mode(ins),
        .idx(reg_wdata[3:0]),
        .store(wr_hit(`TSC_A_SLOT) & reg_wdata[`TSC_S_STORE]),
        .cur_volt(vset_q),
        .cur_timer(timer_q),
        .slot_volt(slot_volt),
        .slot_timer(slot_timer),
        .idx_ok(slot_ok)
    );

    tsc_vcomp u_vcomp
    (
        .vset(vset_q),
        .vmeas(vout_meas),
        .in_tol(in_tol)
    );

    //--------------------------------------------------
    // sequence decisions
    //--------------------------------------------------
    always @*
    begin
        end_pass = 1'b0;
        end_fail = 1'b0;
        abort = 1'b0;
        to_test = 1'b0;
        refuse = 1'b0;
        case (state_q)
            S_RAMP:
            begin
                if (kill)
                    abort = 1'b1;
                else if (tick && ramp_q == 16'h0001)
                begin
                    if (ins || ctrl_q[`TSC_C_CHK_END] || in_tol)
                        to_test = 1'b1;
                    else
                        refuse = 1'b1;
                end
            end
            S_TEST:
            begin
                if (kill)
                    abort = 1'b1;
                else if (judge_fail && judge_ends)
                    end_fail = 1'b1;
                else if (judge_pass && ins && judge_ends)
                    end_pass = 1'b1;
                else if (tick && timer_set && time_q == 16'h0001)
                begin
                    // expiry, judged on the last millisecond
                    if (ins ? (judge_fail | ~judge_pass)
                            : (ctrl_q[`TSC_C_CHK_END] & ~in_tol))
                        end_fail = 1'b1;
                    else
                        end_pass = 1'b1;
                end
            end
            default:
            begin
            end
        endcase
        state_d = state_q;
        case (state_q)
            S_IDLE:
                if (start_ok)
                    state_d = S_RAMP;
            S_RAMP:
                if (abort || refuse)
                    state_d = S_IDLE;
                else if (to_test)
                    state_d = S_TEST;
            S_TEST:
                if (abort)
                    state_d = S_IDLE;
                else if (end_pass)
                    state_d = ctrl_q[`TSC_C_PASS_HOLD] ? S_DONE
                                                       : S_IDLE;
                else if (end_fail)
                    state_d = ctrl_q[`TSC_C_FAIL_HOLD] ? S_DONE
                                                       : S_IDLE;
            S_DONE:
                if (release_ev)
                    state_d = S_IDLE;
            default:
                state_d = S_IDLE;
        endcase
    end

    assign cond = {power_ok, ext_en, ready_q, lock,
                   fail_q, pass_q, test_q, hv_on_q};

    //--------------------------------------------------
    // registers and sequence state
    //--------------------------------------------------
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q <= `TSC_CTRL_RST;
            vset_q <= `TSC_VOLT_RST;
            timer_q <= `TSC_TIMER_RST;
            buzz_q <= `TSC_BUZZ_RST;
            rsel_q <= `TSC_RSEL_RST;
            slot_idx_q <= 4'h0;
            reg_rdata_q <= 16'h0000;
            state_q <= S_IDLE;
            src_q <= 2'h0;
            held_prev_q <= 1'b0;
            stop_prev_q <= 3'h0;
            da_cnt_q <= 25'h0000000;
            ms_cnt_q <= 16'h0000;
            ramp_q <= 16'h0000;
            time_q <= 16'h0000;
            buzz_cnt_q <= 13'h0000;
            refused_q <= 1'b0;
            hv_on_q <= 1'b0;
            test_q <= 1'b0;
            pass_q <= 1'b0;
            fail_q <= 1'b0;
            ready_q <= 1'b0;
            held_value_q <= 16'h0000;
            buzz_on_q <= 1'b0;
            buzz_vol_q <= 4'h0;
            range_auto_q <= 1'b0;
            range_sel_q <= 4'h0;
            external_control_selected_q <= 1'b0;
            relay_q <= 1'b0;
        end
        else
        begin
            if (wr_hit(`TSC_A_CTRL))
                ctrl_q <= reg_wdata;
            if (wr_hit(`TSC_A_BUZZ))
                buzz_q <= reg_wdata;
            if (wr_hit(`TSC_A_RSEL))
                rsel_q <= reg_wdata;
            if (wr_hit(`TSC_A_SLOT))
                slot_idx_q <= reg_wdata[3:0];
            // a slot load wins over a direct write in the same cycle
            if (wr_hit(`TSC_A_SLOT) && reg_wdata[`TSC_S_LOAD] && slot_ok)
            begin
                vset_q <= slot_volt;
                timer_q <= slot_timer;
            end
            else
            begin
                if (wr_hit(`TSC_A_VOLT))
                    vset_q <= reg_wdata;
                if (wr_hit(`TSC_A_TIMER))
                    timer_q <= reg_wdata;
            end
            reg_rdata_q <= 16'h0000;
            if (reg_rd)
            begin
                case (reg_addr)
                    `TSC_A_CTRL: reg_rdata_q <= ctrl_q;
                    `TSC_A_VOLT: reg_rdata_q <= vset_q;
                    `TSC_A_TIMER: reg_rdata_q <= timer_q;
                    `TSC_A_BUZZ: reg_rdata_q <= buzz_q;
                    `TSC_A_RSEL: reg_rdata_q <= rsel_q;
                    `TSC_A_SLOT: reg_rdata_q <= {12'h000, slot_idx_q};
                    `TSC_A_STATUS: reg_rdata_q <= {4'h0, lock, src_q,
                        da_open, refused_q, ready_q, fail_q, pass_q,
                        test_q, hv_on_q, state_q};
                    `TSC_A_HELD: reg_rdata_q <= held_value_q;
                    default: reg_rdata_q <= 16'h0000;
                endcase
            end
            held_prev_q <= held_now;
            stop_prev_q <= stop_now;
            // window opens on each stop press
            if (stop_ev)
                da_cnt_q <= DA_CYC[24:0];
            else if (da_open)
                da_cnt_q <= da_cnt_q - 25'h0000001;
            if (!active || tick)
                ms_cnt_q <= 16'h0000;
            else
                ms_cnt_q <= ms_cnt_q + 16'h0001;
            state_q <= state_d;
            if (start_ok)
            begin
                ramp_q <= RAMP_MS[15:0];
                refused_q <= 1'b0;
                if (pc_start)
                    src_q <= 2'h0;
                else if (remote_start)
                    src_q <= 2'h1;
                else if (ext_start)
                    src_q <= 2'h2;
                else
                    src_q <= 2'h3;
            end
            else if (tick && state_q == S_RAMP)
                ramp_q <= ramp_q - 16'h0001;
            if (refuse)
                refused_q <= 1'b1;
            if (to_test)
                time_q <= timer_q;
            else if (tick && state_q == S_TEST && time_q != 16'h0000)
                time_q <= time_q - 16'h0001;
            // value tracks only while running, so a stop leaves it frozen
            if (state_q == S_TEST && !kill)
                held_value_q <= meas_value;
            if (start_ok)
            begin
                pass_q <= 1'b0;
                fail_q <= 1'b0;
            end
            else if (end_pass)
                pass_q <= 1'b1;
            else if (end_fail)
                fail_q <= 1'b1;
            else if (release_ev && !active)
            begin
                pass_q <= 1'b0;
                fail_q <= 1'b0;
            end
            if (end_pass || end_fail)
            begin
                buzz_cnt_q <= BUZZ_CYC[12:0];
                buzz_on_q <= 1'b1;
                buzz_vol_q <= end_pass ? buzz_q[3:0] : buzz_q[7:4];
            end
            else if (buzz_cnt_q != 13'h0000)
            begin
                buzz_cnt_q <= buzz_cnt_q - 13'h0001;
                buzz_on_q <= (buzz_cnt_q != 13'h0001);
            end
            hv_on_q <= (state_d == S_RAMP) || (state_d == S_TEST);
            test_q <= (state_d == S_TEST);
            ready_q <= (state_d == S_IDLE) && !lock;
            range_auto_q <= ctrl_q[`TSC_C_AUTO_RANGE];
            range_sel_q <= ctrl_q[`TSC_C_RANGE_HI:`TSC_C_RANGE_LO];
            external_control_selected_q <= ext_en;
            relay_q <= |(cond & rsel_q[7:0]);
        end
    end
endmodule
`default_nettype wire

/* File: sim/tsc_seq_ctrl_checker.sv */
// assertion checker for the test sequence controller
`timescale 1ns/100ps
`default_nettype none
module tsc_seq_ctrl_checker
#(
    parameter BUZZ_CYC = 4000
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // observed ports
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata_q,
    input wire logic ext_enable_n,
    input wire logic interlock_n,
    input wire logic hv_on_q,
    input wire logic test_q,
    input wire logic pass_q,
    input wire logic fail_q,
    input wire logic ready_q,
    input wire logic [15:0] held_value_q,
    input wire logic buzz_on_q,
    input wire logic external_control_selected_q
);
    // ----------------------------------------
    // helpers and sequences
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // burst length counted, too long to unroll
    logic [31:0] buzz_cnt_q;
    logic [31:0] buzz_cnt_d;
    assign buzz_cnt_d = buzz_on_q ? buzz_cnt_q + 32'h1 : 32'h0;
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            buzz_cnt_q <= 32'h0;
        else
            buzz_cnt_q <= buzz_cnt_d;
    end
    sequence s_start;
        $rose(hv_on_q);
    endsequence
    sequence s_result;
        $rose(pass_q) || $rose(fail_q);
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_read_data_pulse: assert property (
        !$past(reg_rd) |-> reg_rdata_q == 16'h0)
        else $error("read data outside its cycle");
    a_start_when_ready: assert property (
        s_start |-> $past(ready_q))
        else $error("output started while not ready");
    a_result_exclusive: assert property (
        !(pass_q && fail_q))
        else $error("pass and fail together");
    a_result_ends_test: assert property (
        s_result |-> !hv_on_q && !test_q)
        else $error("output still on at result");
    a_held_frozen: assert property (
        !$past(test_q) |-> $stable(held_value_q))
        else $error("held value moved outside test");
    a_interlock_stops: assert property (
        !interlock_n |-> ##[1:2] (!hv_on_q && !ready_q))
        else $error("interlock did not stop output");
    a_ext_ctrl_follow: assert property (
        $past(rst_b, 2) |-> external_control_selected_q == !$past(ext_enable_n))
        else $error("external control flag wrong");
    a_buzz_length: assert property (
        $fell(buzz_on_q) |-> buzz_cnt_q == BUZZ_CYC)
        else $error("buzzer burst length wrong");
    a_test_has_output: assert property (
        test_q |-> hv_on_q)
        else $error("test without output");
endmodule
bind tsc_seq_ctrl tsc_seq_ctrl_checker #(.BUZZ_CYC(BUZZ_CYC)) chk (
    .mclk(mclk), .rst_b(rst_b), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .ext_enable_n(ext_enable_n), .interlock_n(interlock_n),
    .hv_on_q(hv_on_q), .test_q(test_q), .pass_q(pass_q), .fail_q(fail_q),
    .ready_q(ready_q), .held_value_q(held_value_q), .buzz_on_q(buzz_on_q),
    .external_control_selected_q(external_control_selected_q)
);
`default_nettype wire

/* File: sim/tsc_src_model.sv */
// model of the start and stop sources at the far side
`timescale 1ns/100ps
`default_nettype none
module tsc_src_model
(
    // clock
    input wire logic mclk,
    // requests: bit 0 panel, 1 remote, 2 external
    input wire logic [2:0] start_req,
    input wire logic [2:0] stop_req,
    input wire logic ext_on,
    // key and connector lines
    output logic panel_start,
    output logic panel_stop,
    output logic remote_start,
    output logic remote_stop,
    output logic ext_start_n,
    output logic ext_stop_n,
    output logic ext_enable_n
);
    initial {panel_start, panel_stop, remote_start, remote_stop} = 4'h0;
    initial {ext_start_n, ext_stop_n, ext_enable_n} = 3'h7;
    // keys held as levels for as long as asked, no debounce modelled
    always @(posedge mclk)
    begin
        panel_start <= start_req[0];
        remote_start <= start_req[1];
        ext_start_n <= ~start_req[2];
        panel_stop <= stop_req[0];
        remote_stop <= stop_req[1];
        ext_stop_n <= ~stop_req[2];
        ext_enable_n <= ~ext_on;
    end
endmodule
`default_nettype wire

/* File: sim/tsc_seq_ctrl_test.sv */
// self-checking bench for the test sequence controller
`timescale 1ns/100ps
`default_nettype none
`include "tsc_map.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
`define WAITC(c) begin for (int w = 0; w < 600 && !(c); w++) @(posedge mclk) #1; \
    if (!(c)) begin num_errors++; $display("BAD %0t wait timed out", $time); end end
module tsc_seq_ctrl_test;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [2:0] start_req = 3'h0;
    logic [2:0] stop_req = 3'h0;
    logic ext_on = 1'b0;
    logic interlock_n = 1'b1;
    logic [15:0] vout_meas = 16'h0000;
    logic [15:0] meas_value = 16'h0000;
    logic judge_pass = 1'b0;
    logic judge_fail = 1'b0;
    logic power_ok = 1'b0;
    wire panel_start, panel_stop, remote_start, remote_stop;
    wire ext_start_n, ext_stop_n, ext_enable_n;
    wire [15:0] reg_rdata_q, vset_q, held_value_q;
    wire hv_on_q, test_q, pass_q, fail_q, ready_q, buzz_on_q;
    wire range_auto_q, external_control_selected_q, relay_q;
    wire [3:0] buzz_vol_q, range_sel_q;
    int num_errors = 0;
    int compares = 0;
    logic [15:0] rv, pv, fv, vs, vo;
    logic ce = 1'b0;
    logic [7:0] addrs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h24};
    logic [15:0] cv [8] = '{16'h03e8, 16'h041a, 16'h03e8, 16'h03b5,
        16'h07d0, 16'h0834, 16'h07d0, 16'h076b};
    always #12.5 mclk = ~mclk;
    tsc_src_model src (.*);
    // short counts keep the run small
    tsc_seq_ctrl #(.DA_CYC(20), .MS_CYC(10), .RAMP_MS(2), .BUZZ_CYC(5)) dut (.*);
    // ----------------------------------------
    // bus, key and check helpers
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask
    task automatic press(input logic [2:0] st, input logic [2:0] sp);
        @(posedge mclk);
        start_req <= st;
        stop_req <= sp;
        repeat (2) @(posedge mclk);
        start_req <= 3'h0;
        stop_req <= 3'h0;
    endtask
    function automatic logic win_ok(input logic [15:0] s, input logic [15:0] o);
        logic [15:0] tol;
        tol = (s <= `TSC_LOW_KV_V) ? `TSC_FIX_TOL_V : s / `TSC_PCT_DIV;
        return ((o > s) ? o - s : s - o) <= tol;
    endfunction
    task automatic run_w(input logic [15:0] s, input logic [15:0] o);
        wr(`TSC_A_VOLT, s);
        vout_meas <= o;
        press(3'b001, 3'b000);
        `WAITC(hv_on_q);
        `WAITC(!hv_on_q);
        if (win_ok(s, o)) `CHK(buzz_vol_q, pv)
        rd(`TSC_A_STATUS, rv);
        `CHK(pass_q, win_ok(s, o))
        `CHK(rv[7], !win_ok(s, o) && !ce)
        `CHK(rv[5], !win_ok(s, o) && ce)
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #1000000;
        num_errors++;
        $display("BAD %0t watchdog expired", $time);
        give_verdict();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h8dc8ce57));
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        foreach (addrs[i])
        begin
            rd(addrs[i], rv);
            `CHK(rv, 16'h0000)
        end
        $display("done: reset values");
        pv = 16'($urandom_range(15));
        fv = 16'($urandom_range(15));
        wr(`TSC_A_BUZZ, {8'h00, fv[3:0], pv[3:0]});
        wr(`TSC_A_TIMER, 16'h0002);
        for (int i = 0; i < 8; i += 2)
            run_w(cv[i], cv[i + 1]);
        repeat (4)
        begin
            vs = 16'h03e9 + 16'($urandom_range(3000));
            run_w(vs, vs - 16'h0096 + 16'($urandom_range(300)));
        end
        ce = 1'b1;
        wr(`TSC_A_CTRL, 16'h0002);
        run_w(cv[0], cv[1]);
        run_w(cv[2], cv[3]);
        ce = 1'b0;
        $display("done: voltage window");
        wr(`TSC_A_CTRL, 16'h0004);
        run_w(16'h07d0, 16'h07d0);
        press(3'b001, 3'b000);
        repeat (30) @(posedge mclk);
        `CHK(hv_on_q, 1'b0)
        `CHK(pass_q, 1'b1)
        press(3'b000, 3'b001);
        repeat (3) @(posedge mclk);
        `CHK(pass_q, 1'b0)
        $display("done: pass hold");
        wr(`TSC_A_CTRL, 16'h0048);
        wr(`TSC_A_TIMER, 16'h0000);
        press(3'b001, 3'b000);
        `WAITC(test_q);
        vs = 16'($urandom);
        meas_value <= vs;
        repeat (3) @(posedge mclk);
        judge_fail <= 1'b1;
        `WAITC(fail_q);
        `CHK(buzz_vol_q, fv[3:0])
        judge_fail <= 1'b0;
        meas_value <= ~vs;
        press(3'b000, 3'b110);
        repeat (4) @(posedge mclk);
        `CHK(fail_q, 1'b1)
        press(3'b000, 3'b001);
        repeat (3) @(posedge mclk);
        `CHK(fail_q, 1'b0)
        $display("done: fail hold");
        wr(`TSC_A_CTRL, 16'h0000);
        press(3'b001, 3'b000);
        `WAITC(test_q);
        repeat (3) @(posedge mclk);
        press(3'b000, 3'b001);
        meas_value <= vs;
        repeat (4) @(posedge mclk);
        `CHK(hv_on_q, 1'b0)
        rd(`TSC_A_HELD, rv);
        `CHK(rv, ~vs)
        $display("done: forced stop");
        wr(`TSC_A_CTRL, 16'h0010);
        ext_on <= 1'b1;
        start_req <= 3'b100;
        `WAITC(test_q);
        `CHK(test_q, 1'b1)
        rd(`TSC_A_STATUS, rv);
        `CHK(rv[10:9], 2'h2)
        start_req <= 3'b000;
        repeat (4) @(posedge mclk);
        `CHK(hv_on_q, 1'b0)
        ext_on <= 1'b0;
        $display("done: momentary");
        wr(`TSC_A_CTRL, 16'h0020);
        wr(`TSC_A_TIMER, 16'h0002);
        press(3'b000, 3'b001);
        repeat (30) @(posedge mclk);
        press(3'b001, 3'b000);
        repeat (4) @(posedge mclk);
        `CHK(hv_on_q, 1'b0)
        press(3'b000, 3'b001);
        press(3'b001, 3'b000);
        #1 `CHK(hv_on_q, 1'b1)
        `WAITC(!hv_on_q);
        $display("done: double action");
        wr(`TSC_A_CTRL, 16'h0000);
        wr(`TSC_A_CMD, 16'h0001);
        repeat (4) @(posedge mclk);
        `CHK(hv_on_q, 1'b0)
        wr(`TSC_A_CTRL, 16'h0080);
        wr(`TSC_A_CMD, 16'h0001);
        rd(`TSC_A_STATUS, rv);
        `CHK(rv[10:9], 2'h0)
        `WAITC(!hv_on_q);
        $display("done: pc start");
        wr(`TSC_A_CTRL, 16'h0101);
        wr(`TSC_A_TIMER, 16'h0032);
        press(3'b001, 3'b000);
        `WAITC(test_q);
        judge_pass <= 1'b1;
        repeat (4) @(posedge mclk);
        `CHK(pass_q, 1'b1)
        judge_pass <= 1'b0;
        $display("done: end on judgement");
        wr(`TSC_A_VOLT, 16'h0555);
        wr(`TSC_A_SLOT, 16'h0109);
        wr(`TSC_A_VOLT, 16'h0005);
        wr(`TSC_A_SLOT, 16'h020a);
        rd(`TSC_A_VOLT, rv);
        `CHK(rv, 16'h0005)
        wr(`TSC_A_SLOT, 16'h0209);
        rd(`TSC_A_VOLT, rv);
        `CHK(rv, 16'h0555)
        wr(`TSC_A_CTRL, 16'ha200);
        wr(`TSC_A_RSEL, 16'h0090);
        power_ok <= 1'b1;
        repeat (4) @(posedge mclk);
        `CHK({range_auto_q, range_sel_q}, 5'h1a)
        `CHK(relay_q, 1'b1)
        power_ok <= 1'b0;
        repeat (4) @(posedge mclk);
        `CHK(relay_q, 1'b0)
        interlock_n <= 1'b0;
        repeat (4) @(posedge mclk);
        `CHK({relay_q, ready_q}, 2'h2)
        $display("done: slots, range, relay");
        give_verdict();
    end
endmodule
`default_nettype wire
